// *** hdl/mitc_defines.vh ***
`ifndef MITC_DEFINES_VH
`define MITC_DEFINES_VH
// Instruction cycle length in system clocks
`define MITC_CLKS_PER_CYCLE 4
`define MITC_PHASE_LAST 2'h3
// Program counter width and reset value, stack depth, reset byte
`define MITC_PC_W 10
`define MITC_PC_RESET 10'h000
`define MITC_STACK_DEPTH 4
`define MITC_RESET_BYTE 8'h00
// Operation class codes (op field of decoded instruction)
`define MITC_OP_NOP 5'h00
`define MITC_OP_ADD 5'h01
`define MITC_OP_ADC 5'h02
`define MITC_OP_SUB 5'h03
`define MITC_OP_SBC 5'h04
`define MITC_OP_AND 5'h05
`define MITC_OP_OR 5'h06
`define MITC_OP_XOR 5'h07
`define MITC_OP_COMPL 5'h08
`define MITC_OP_INC 5'h09
`define MITC_OP_DEC 5'h0a
`define MITC_OP_ROT_R 5'h0b
`define MITC_OP_ROT_L 5'h0c
`define MITC_OP_ROT_RC 5'h0d
`define MITC_OP_ROT_LC 5'h0e
`define MITC_OP_MOVA 5'h0f
`define MITC_OP_MOVM 5'h10
`define MITC_OP_BCLR 5'h11
`define MITC_OP_BSET 5'h12
`define MITC_OP_SZ 5'h13
`define MITC_OP_SZB 5'h14
`define MITC_OP_SNZB 5'h15
`define MITC_OP_SIZ 5'h16
`define MITC_OP_SDZ 5'h17
`define MITC_OP_JUMP 5'h18
`define MITC_OP_CALL 5'h19
`define MITC_OP_RETURN 5'h1a
`define MITC_OP_IRETURN 5'h1b
`define MITC_OP_TABRD 5'h1c
`define MITC_OP_HALT 5'h1d
// Instruction word fields: [15:11] op, [10] imm, [9] toAcc, [8] bit/addr msb region
`define MITC_INSTR_W 16
`define MITC_F_OP_HI 15
`define MITC_F_OP_LO 11
`define MITC_F_IMM 10
`define MITC_F_TOACC 9
// Data memory address of the program counter low byte
`define MITC_PC_LOW_ADDR 8'h06
`endif

// *** hdl/mitc_phase_gen.v ***
`timescale 1ns/1ps
`default_nettype none
`include "mitc_defines.vh"
module mitc_phase_gen (
  // Clock and reset
  input wire core_clk,
  input wire rst,
  // Phase outputs
  output wire [1:0] phase,
  output wire cycleEnd
);
  reg [1:0] phase_r;
  // Divide system clock by four
  always @(posedge core_clk) begin
    if (rst) begin
      phase_r <= 2'h0;
    end else begin
      phase_r <= phase_r + 2'h1; // [RQ2]
    end
  end
  assign phase = phase_r;
  assign cycleEnd = (phase_r == `MITC_PHASE_LAST); // [RQ2]
endmodule
`default_nettype wire

// *** hdl/mitc_core.v ***
// Functional notes
// [RQ1] Most instructions take one cycle; jump, call, return, table read take two.
// [RQ2] One instruction cycle equals four system clocks.
// [RQ3] Writing the program counter low byte adds one cycle.
// [RQ4] Taken skip adds one cycle; untaken skip takes one.
// [RQ5] Logical operations set zero flag when result is zero.
// [RQ6] Rotates shift one bit; through-carry variants move out bit to carry.
// [RQ7] Bit set and clear change only the addressed bit.
// [RQ8] Return resumes after the call; jump saves no return point.
// [RQ9] Increment and decrement change value by one, to memory or accumulator.
// [RQ10] Conditional tests a byte or bit then proceeds or skips.
// [RQ11] Add reports carry above 255; subtract reports borrow below zero.
// [RQ12] Moves: memory to accumulator, accumulator to memory, immediate to accumulator.
// [RQ13] Table read fetches fixed data from program memory.
// [RQ14] Halt instruction enters power-down.
// [RQ15] Two-cycle instructions discard the prefetch and refetch from new address; table read keeps the prefetched word instead.
`timescale 1ns/1ps
`default_nettype none
`include "mitc_defines.vh"
module mitc_core (
  // Clock and reset
  input wire core_clk,
  input wire rst,
  // Program memory
  output reg [9:0] progAddr,
  input wire [15:0] progData,
  // Data memory
  output reg [7:0] dataAddr,
  input wire [7:0] dataRdata,
  output reg [7:0] dataWdata,
  output reg dataWe,
  // Table pointer and status
  input wire [9:0] tablePtr,
  output reg [7:0] tableHigh,
  output reg [7:0] acc,
  output reg zeroFlag,
  output reg carryFlag,
  output reg powerDown,
  output reg retiSeen,
  output wire cycleEnd
);
  // Pipeline and program counter state
  reg [9:0] pc_r;
  reg [15:0] instr_r;
  reg instrValid_r;
  reg flushLeft_r;
  reg tableLoad_r;
  reg [9:0] stack_r [0:3];
  reg [1:0] sp_r;
  reg [7:0] wrAddr_r;
  wire [1:0] phase;
  // Decoded fields
  wire [4:0] op = instr_r[`MITC_F_OP_HI:`MITC_F_OP_LO];
  wire useImm = instr_r[`MITC_F_IMM];
  wire toAcc = instr_r[`MITC_F_TOACC];
  wire [7:0] mAddr = instr_r[7:0];
  wire [2:0] bitSel = instr_r[10:8];
  wire [9:0] target = instr_r[9:0];
  wire [7:0] operand = useImm ? instr_r[7:0] : dataRdata;
  // Execution results
  reg [7:0] result;
  reg [8:0] wide;
  reg wrMem, wrAcc, setZ, setC, newC, doSkip, doBranch, doCall, doRet;
  reg [9:0] branchPc;

  mitc_phase_gen u_phase (
    .core_clk(core_clk),
    .rst(rst),
    .phase(phase),
    .cycleEnd(cycleEnd)
  );

  // Single bit mask, used by set, clear and bit tests
  function [7:0] bitMask;
    input [2:0] sel;
    begin
      bitMask = 8'h01 << sel;
    end
  endfunction

  // Zero test on a byte
  function isZero;
    input [7:0] v;
    begin
      isZero = (v == 8'h00);
    end
  endfunction

  // Data memory address follows the executing instruction, except in the write clock
  // The write lands after instr_r has moved on, so its address is held apart
  always @* begin
    dataAddr = dataWe ? wrAddr_r : mAddr; // [RQ7]
    progAddr = tableLoad_r ? tablePtr : pc_r; // [RQ13]
  end

  // Execute stage decode
  always @* begin
    result = 8'h00;
    wide = 9'h000;
    wrMem = 1'b0;
    wrAcc = 1'b0;
    setZ = 1'b0;
    setC = 1'b0;
    newC = carryFlag;
    doSkip = 1'b0;
    doBranch = 1'b0;
    doCall = 1'b0;
    doRet = 1'b0;
    branchPc = target;
    case (op)
      `MITC_OP_ADD, `MITC_OP_ADC: begin
        wide = {1'b0, acc} + {1'b0, operand} + {8'h00, (op == `MITC_OP_ADC) & carryFlag};
        result = wide[7:0];
        setC = 1'b1;
        newC = wide[8]; // [RQ11]
        setZ = 1'b1;
      end
      `MITC_OP_SUB, `MITC_OP_SBC: begin
        wide = {1'b0, acc} - {1'b0, operand} - {8'h00, (op == `MITC_OP_SBC) & ~carryFlag};
        result = wide[7:0];
        setC = 1'b1;
        newC = ~wide[8]; // [RQ11] carry clear means borrow
        setZ = 1'b1;
      end
      `MITC_OP_AND: begin
        result = acc & operand;
        setZ = 1'b1; // [RQ5]
      end
      `MITC_OP_OR: begin
        result = acc | operand;
        setZ = 1'b1; // [RQ5]
      end
      `MITC_OP_XOR: begin
        result = acc ^ operand;
        setZ = 1'b1; // [RQ5]
      end
      `MITC_OP_COMPL: begin
        result = ~dataRdata;
        setZ = 1'b1; // [RQ5]
      end
      `MITC_OP_INC: begin
        result = dataRdata + 8'h01; // [RQ9]
        setZ = 1'b1;
      end
      `MITC_OP_DEC: begin
        result = dataRdata - 8'h01; // [RQ9]
        setZ = 1'b1;
      end
      `MITC_OP_ROT_R: result = {dataRdata[0], dataRdata[7:1]}; // [RQ6]
      `MITC_OP_ROT_L: result = {dataRdata[6:0], dataRdata[7]}; // [RQ6]
      `MITC_OP_ROT_RC: begin
        result = {carryFlag, dataRdata[7:1]};
        setC = 1'b1;
        newC = dataRdata[0]; // [RQ6]
      end
      `MITC_OP_ROT_LC: begin
        result = {dataRdata[6:0], carryFlag};
        setC = 1'b1;
        newC = dataRdata[7]; // [RQ6]
      end
      `MITC_OP_MOVA: result = operand; // [RQ12]
      `MITC_OP_MOVM: result = acc; // [RQ12]
      `MITC_OP_BCLR: result = dataRdata & ~bitMask(bitSel); // [RQ7]
      `MITC_OP_BSET: result = dataRdata | bitMask(bitSel); // [RQ7]
      `MITC_OP_SZ: begin
        result = dataRdata;
        doSkip = isZero(dataRdata); // [RQ10]
      end
      `MITC_OP_SZB: doSkip = isZero(dataRdata & bitMask(bitSel)); // [RQ10]
      `MITC_OP_SNZB: doSkip = ~isZero(dataRdata & bitMask(bitSel)); // [RQ10]
      `MITC_OP_SIZ: begin
        result = dataRdata + 8'h01; // [RQ9]
        doSkip = isZero(result); // [RQ10]
      end
      `MITC_OP_SDZ: begin
        result = dataRdata - 8'h01; // [RQ9]
        doSkip = isZero(result); // [RQ10]
      end
      `MITC_OP_JUMP: doBranch = 1'b1; // [RQ8] no stack push
      `MITC_OP_CALL: begin
        doBranch = 1'b1;
        doCall = 1'b1;
      end
      `MITC_OP_RETURN, `MITC_OP_IRETURN: begin
        doBranch = 1'b1;
        doRet = 1'b1;
        branchPc = stack_r[sp_r - 2'h1]; // [RQ8]
      end
      default: result = 8'h00;
    endcase
    // Destination select: accumulator forms versus memory forms
    case (op)
      `MITC_OP_ADD, `MITC_OP_ADC, `MITC_OP_SUB, `MITC_OP_SBC, `MITC_OP_AND, `MITC_OP_OR,
      `MITC_OP_XOR, `MITC_OP_MOVA: begin
        wrAcc = ~toAcc | useImm;
        wrMem = toAcc & ~useImm;
      end
      `MITC_OP_COMPL, `MITC_OP_INC, `MITC_OP_DEC, `MITC_OP_ROT_R, `MITC_OP_ROT_L, `MITC_OP_ROT_RC,
      `MITC_OP_ROT_LC, `MITC_OP_SZ, `MITC_OP_SIZ, `MITC_OP_SDZ: begin
        wrAcc = toAcc; // [RQ9]
        wrMem = ~toAcc & (op != `MITC_OP_SZ);
      end
      `MITC_OP_MOVM, `MITC_OP_BCLR, `MITC_OP_BSET: wrMem = 1'b1;
      default: wrMem = 1'b0;
    endcase
    // Low byte of program counter written: behaves as a jump
    if (wrMem && mAddr == `MITC_PC_LOW_ADDR) begin
      doBranch = 1'b1; // [RQ3]
      branchPc = {pc_r[9:8], result};
    end
  end

  // Datapath, flags, program counter and stack, advanced once per instruction cycle
  always @(posedge core_clk) begin
    if (rst) begin
      pc_r <= `MITC_PC_RESET;
      instr_r <= 16'h0000;
      instrValid_r <= 1'b0;
      flushLeft_r <= 1'b0;
      tableLoad_r <= 1'b0;
      sp_r <= 2'h0;
      wrAddr_r <= `MITC_RESET_BYTE;
      acc <= `MITC_RESET_BYTE;
      zeroFlag <= 1'b0;
      carryFlag <= 1'b0;
      powerDown <= 1'b0;
      retiSeen <= 1'b0;
      tableHigh <= `MITC_RESET_BYTE;
      dataWdata <= `MITC_RESET_BYTE;
      dataWe <= 1'b0;
    end else begin
      dataWe <= 1'b0;
      retiSeen <= 1'b0;
      if (cycleEnd && !powerDown) begin
        if (tableLoad_r) begin
          // Second cycle of table read: latch the table word
          tableHigh <= progData[15:8];
          acc <= progData[7:0]; // [RQ13]
          tableLoad_r <= 1'b0;
          // Prefetched word kept valid so the table read costs only two cycles
          pc_r <= pc_r + 10'h001; // [RQ1]
        end else if (flushLeft_r) begin
          // Extra cycle: prefetched word dropped, refetch at new pc
          flushLeft_r <= 1'b0; // [RQ1] [RQ15]
          instr_r <= progData;
          instrValid_r <= 1'b1;
          pc_r <= pc_r + 10'h001;
        end else begin
          instr_r <= progData;
          instrValid_r <= 1'b1;
          pc_r <= pc_r + 10'h001;
          if (instrValid_r) begin
            if (wrAcc) acc <= result;
            if (wrMem) begin
              dataWdata <= result; // [RQ7]
              wrAddr_r <= mAddr;
              dataWe <= 1'b1;
            end
            if (setZ) zeroFlag <= isZero(result); // [RQ5]
            if (setC) carryFlag <= newC;
            if (op == `MITC_OP_HALT) begin
              powerDown <= 1'b1; // [RQ14]
              instrValid_r <= 1'b0;
            end
            if (op == `MITC_OP_IRETURN) retiSeen <= 1'b1;
            if (op == `MITC_OP_TABRD) begin
              tableLoad_r <= 1'b1; // [RQ1] [RQ13]
              pc_r <= pc_r;
            end
            if (doCall) begin
              stack_r[sp_r] <= pc_r; // [RQ8] pc already points past the call
              sp_r <= sp_r + 2'h1;
            end
            if (doRet) sp_r <= sp_r - 2'h1; // [RQ8]
            if (doBranch) begin
              pc_r <= branchPc; // [RQ1] [RQ3] [RQ15]
              flushLeft_r <= 1'b1;
              instrValid_r <= 1'b0;
            end
            if (doSkip) begin
              flushLeft_r <= 1'b1; // [RQ4] [RQ15]
              instrValid_r <= 1'b0;
            end
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** bench/mitc_core_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module mitc_core_properties (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Watched outputs
  input wire logic [7:0] acc,
  input wire logic zeroFlag,
  input wire logic carryFlag,
  input wire logic dataWe,
  input wire logic powerDown,
  input wire logic cycleEnd
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Delayed cycle ends, so results may land one or two clocks after the close
  logic end1_r, end2_r, rst1_r;
  always @(posedge core_clk) begin
    end1_r <= cycleEnd;
    end2_r <= end1_r;
    rst1_r <= rst;
  end
  cycle_period_a:
    assert property (cycleEnd ##1 !powerDown |-> !cycleEnd [*3] ##1 (cycleEnd || powerDown)) else $error("bad cycle");
  halt_sticky_a:
    assert property (powerDown |=> powerDown) else $error("halt released");
  halt_quiet_a:
    assert property (powerDown |-> !dataWe ##1 $stable(acc)) else $error("activity in halt");
  write_pulse_a:
    assert property (dataWe |=> !dataWe) else $error("long write");
  write_time_a:
    assert property (dataWe |-> end1_r || end2_r) else $error("write off cycle");
  acc_time_a:
    assert property ($changed(acc) && !rst1_r |-> end1_r || end2_r) else $error("acc mid cycle");
  flag_time_a:
    assert property ($changed({zeroFlag, carryFlag}) && !rst1_r |-> end1_r || end2_r) else $error("flags mid cycle");
  halt_time_a:
    assert property ($rose(powerDown) |-> end1_r || end2_r) else $error("halt off cycle");
  // Main scenarios reached
  cover property ($rose(powerDown));
  cover property (dataWe);
  cover property ($rose(carryFlag));
endmodule
bind mitc_core mitc_core_properties chk_u (.core_clk(core_clk), .rst(rst), .acc(acc), .zeroFlag(zeroFlag),
  .carryFlag(carryFlag), .dataWe(dataWe), .powerDown(powerDown), .cycleEnd(cycleEnd));
`default_nettype wire

// *** bench/mitc_mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module mitc_mem_model (
  // Clock
  input wire logic core_clk,
  // Program side
  input wire logic [9:0] progAddr,
  output logic [15:0] progData,
  // Data side
  input wire logic [7:0] dataAddr,
  output logic [7:0] dataRdata,
  input wire logic [7:0] dataWdata,
  input wire logic dataWe
);
  logic [15:0] pmem [0:1023];
  logic [7:0] dmem [0:255];
  // Reads are combinational, as the core expects
  assign progData = pmem[progAddr];
  assign dataRdata = dmem[dataAddr];
  // Write lands on the edge that sees the pulse
  always @(posedge core_clk) begin
    if (dataWe) begin
      dmem[dataAddr] <= dataWdata;
    end
  end
endmodule
`default_nettype wire

// *** bench/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "mitc_defines.vh"
module tb;
  typedef struct {logic [15:0] x, y, z; logic [7:0] v; logic zf, cf; int c;} mitc_row_t;
  localparam logic [15:0] H = {`MITC_OP_HALT, 11'h000};
  // Stimulus and observed outputs
  logic core_clk, rst;
  logic [9:0] tablePtr;
  wire [9:0] progAddr;
  wire [15:0] progData;
  wire [7:0] dataAddr, dataRdata, dataWdata, tableHigh, acc;
  wire dataWe, zeroFlag, carryFlag, powerDown, cycleEnd, retiSeen;
  int errors, total_checks, n, retiCount;
  mitc_row_t rows[$];
  mitc_core dut_u (.core_clk(core_clk), .rst(rst), .progAddr(progAddr), .progData(progData), .dataAddr(dataAddr),
    .dataRdata(dataRdata), .dataWdata(dataWdata), .dataWe(dataWe), .tablePtr(tablePtr), .tableHigh(tableHigh),
    .acc(acc), .zeroFlag(zeroFlag), .carryFlag(carryFlag), .powerDown(powerDown), .retiSeen(retiSeen),
    .cycleEnd(cycleEnd));
  // Interrupt-return pulses seen
  always @(posedge core_clk) if (retiSeen === 1'b1) retiCount++;
  mitc_mem_model mem_u (.core_clk(core_clk), .progAddr(progAddr), .progData(progData), .dataAddr(dataAddr),
    .dataRdata(dataRdata), .dataWdata(dataWdata), .dataWe(dataWe));
  // 250 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  function automatic logic [15:0] w(input logic [4:0] op, input logic [2:0] m, input logic [7:0] lo);
    return {op, m, lo};
  endfunction
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic a(input logic [15:0] x, y, z, input logic [7:0] v, input logic zf, cf, input int c);
    rows.push_back('{x, y, z, v, zf, cf, c});
  endtask
  // Reset, load a short program, run until halt; n counts clocks
  task automatic run(input logic [15:0] x, y, z);
    @(posedge core_clk);
    #1 rst = 1'b1;
    for (int i = 0; i < 256; i++) mem_u.dmem[i] = i[7:0];
    mem_u.pmem[0] = x;
    mem_u.pmem[1] = y;
    mem_u.pmem[2] = z;
    repeat (6) @(posedge core_clk);
    #1 rst = 1'b0;
    n = 0;
    while (powerDown !== 1'b1 && n < 200) begin
      @(posedge core_clk);
      #1 n++;
    end
  endtask
  task automatic stop_test();
    $display("errors %0d checks %0d", errors, total_checks);
    if (errors == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Watchdog against a hung core
  initial begin
    #40000;
    errors++;
    stop_test();
  end
  initial begin
    rst = 1'b1;
    tablePtr = 10'h3f0;
    errors = 0;
    total_checks = 0;
    retiCount = 0;
    for (int i = 0; i < 1024; i++) mem_u.pmem[i] = H;
    mem_u.pmem[4] = w(`MITC_OP_RETURN, 3'h0, 8'h00);
    mem_u.pmem[5] = w(`MITC_OP_IRETURN, 3'h0, 8'h00);
    mem_u.pmem[10'h3f0] = 16'hbeef;
    // Program, expected acc, zero, carry, cycles before halt
    a(w(`MITC_OP_INC, 2, 8'h30), H, H, 8'h31, 0, 0, 1);
    a(w(`MITC_OP_DEC, 2, 8'h00), H, H, 8'hff, 0, 0, 1);
    a(w(`MITC_OP_MOVA, 4, 8'h5a), w(`MITC_OP_AND, 4, 8'ha5), H, 8'h00, 1, 0, 2);
    a(w(`MITC_OP_OR, 4, 8'hf0), w(`MITC_OP_XOR, 4, 8'hf0), H, 8'h00, 1, 0, 2);
    a(w(`MITC_OP_COMPL, 2, 8'hff), H, H, 8'h00, 1, 0, 1);
    a(w(`MITC_OP_MOVA, 4, 8'hff), w(`MITC_OP_ADD, 4, 8'h01), H, 8'h00, 1, 1, 2);
    a(w(`MITC_OP_MOVA, 4, 8'h10), w(`MITC_OP_SUB, 4, 8'h20), H, 8'hf0, 0, 0, 2);
    a(w(`MITC_OP_ROT_R, 2, 8'h01), H, H, 8'h80, 0, 0, 1);
    a(w(`MITC_OP_ROT_L, 2, 8'h81), H, H, 8'h03, 0, 0, 1);
    a(w(`MITC_OP_ROT_RC, 2, 8'h81), H, H, 8'h40, 0, 1, 1);
    a(w(`MITC_OP_ROT_LC, 2, 8'h80), H, H, 8'h00, 0, 1, 1);
    a(w(`MITC_OP_MOVA, 0, 8'h3c), H, H, 8'h3c, 0, 0, 1);
    a(w(`MITC_OP_MOVA, 4, 8'h02), w(`MITC_OP_MOVM, 1, 8'h06), H, 8'h02, 0, 0, 3);
    a(w(`MITC_OP_JUMP, 0, 8'h02), w(`MITC_OP_MOVA, 4, 8'h99), H, 8'h00, 0, 0, 2);
    a(w(`MITC_OP_SZB, 0, 8'h01), w(`MITC_OP_MOVA, 4, 8'h99), H, 8'h99, 0, 0, 2);
    a(w(`MITC_OP_CALL, 0, 8'h05), w(`MITC_OP_MOVA, 4, 8'h22), H, 8'h22, 0, 0, 5);
    a(w(`MITC_OP_SZ, 0, 8'h00), w(`MITC_OP_MOVA, 4, 8'h99), H, 8'h00, 0, 0, 2);
    a(w(`MITC_OP_SZ, 0, 8'h01), w(`MITC_OP_MOVA, 4, 8'h99), H, 8'h99, 0, 0, 2);
    a(w(`MITC_OP_SNZB, 0, 8'h01), w(`MITC_OP_MOVA, 4, 8'h99), H, 8'h00, 0, 0, 2);
    a(w(`MITC_OP_SIZ, 0, 8'hff), w(`MITC_OP_MOVA, 4, 8'h99), H, 8'h00, 0, 0, 2);
    a(w(`MITC_OP_CALL, 0, 8'h04), w(`MITC_OP_MOVA, 4, 8'h11), H, 8'h11, 0, 0, 5);
    a(w(`MITC_OP_TABRD, 0, 8'h00), H, H, 8'hef, 0, 0, 2);
    foreach (rows[k]) begin
      run(rows[k].x, rows[k].y, rows[k].z);
      // Fetch at the fourth edge after release, halt seen on the edge that executes it, one cycle after its fetch
      chk("cycles", 2 * `MITC_CLKS_PER_CYCLE + `MITC_CLKS_PER_CYCLE * rows[k].c, n);
      chk("acc", rows[k].v, acc);
      chk("flags", {rows[k].zf, rows[k].cf}, {zeroFlag, carryFlag});
    end
    chk("table high", 8'hbe, tableHigh);
    chk("interrupt_return pulses", 16'h0001, retiCount[15:0]);
    // Reset while halted clears what the last program left
    #1 rst = 1'b1;
    repeat (6) @(posedge core_clk);
    #1 chk("reset", 16'h0000, {acc, zeroFlag, carryFlag, powerDown, dataWe});
    run(w(`MITC_OP_BSET, 3, 8'h40), w(`MITC_OP_BCLR, 6, 8'h41), H);
    chk("set bit", 8'h48, mem_u.dmem[8'h40]);
    chk("clear bit", 8'h01, mem_u.dmem[8'h41]);
    chk("neighbour", 8'h42, mem_u.dmem[8'h42]);
    stop_test();
  end
endmodule
`default_nettype wire
